/* File: logic/fld_log_decode.sv */
// Logarithm instruction decoder with special-operand result and exception update
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fld_log_decode #(
  parameter int RES_W = 80
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Configuration
  input wire logic [fld_pkg::FLD_CP_ID_W-1:0] cp_id_i,
  // Instruction from host
  input wire logic cmd_valid_i,
  input wire fld_pkg::fld_word1_t word1_i,
  input wire fld_pkg::fld_word2_t word2_i,
  // Operand class and computed value from the arithmetic core
  input wire logic core_done_i,
  input wire fld_pkg::fld_class_t src_class_i,
  input wire logic [RES_W-1:0] core_result_i,
  input wire logic [RES_W-1:0] nan_value_i,
  input wire logic [RES_W-1:0] inf_pos_i,
  input wire logic [RES_W-1:0] inf_neg_i,
  // Decode towards the core
  output logic accept_o,
  output fld_pkg::fld_decode_t decode_o,
  output logic busy_o,
  // Register write back
  output logic wr_en_o,
  output logic [2:0] wr_reg_o,
  output logic [RES_W-1:0] wr_data_o,
  // Status bytes
  output logic [7:0] exc_byte_o,
  output logic [4:0] acc_byte_o,
  output logic irq_o
);
  import fld_pkg::*;

  fld_state_t state_q, state_d;
  fld_decode_t dec_q;
  logic accept_q;
  logic wr_en_q;
  logic [2:0] wr_reg_q;
  logic [RES_W-1:0] wr_data_q;
  logic [7:0] exc_q;
  logic [4:0] acc_q;
  logic irq_q;

  // First and second word matching
  wire logic id_hit;
  wire logic op_l10;
  wire logic op_l2;
  wire logic hit;
  wire logic take;
  wire fld_decode_t dec_w;
  assign id_hit = (word1_i.cp_id == cp_id_i);
  assign op_l10 = (word2_i.opmode == FLD_OP_LOG10);
  assign op_l2 = (word2_i.opmode == FLD_OP_LOG2);
  assign hit = (word1_i.line == FLD_LINE_F) && (word1_i.kind == FLD_TYPE_GENERAL) && id_hit
               && !word2_i.zero15 && !word2_i.zero13 && (op_l10 || op_l2);
  assign take = cmd_valid_i && hit && (state_q == FLD_IDLE);

  // Field decode; the effective-address fields are dropped when register to register
  assign dec_w.valid = 1'b1;
  assign dec_w.log_two = op_l2;
  assign dec_w.rm = word2_i.rm;
  assign dec_w.src_reg = word2_i.rm ? 3'h0 : word2_i.src_spec;
  assign dec_w.fmt = word2_i.rm ? word2_i.src_spec : FLD_FMT_EXT;
  assign dec_w.dst_reg = word2_i.dst_reg;
  assign dec_w.ea_mode = word2_i.rm ? word1_i.ea_mode : 3'h0;
  assign dec_w.ea_reg = word2_i.rm ? word1_i.ea_reg : 3'h0;
  assign dec_w.need_convert = word2_i.rm && (word2_i.src_spec != FLD_FMT_EXT);

  // Special-operand result selection
  wire logic neg_bad;
  wire logic is_zero;
  wire logic pos_inf;
  wire logic [RES_W-1:0] res_w;
  wire logic [7:0] exc_w;
  wire logic [4:0] acc_w;
  assign neg_bad = src_class_i.sign && !src_class_i.is_zero && !src_class_i.is_nan;
  assign is_zero = src_class_i.is_zero && !src_class_i.is_nan;
  assign pos_inf = src_class_i.is_inf && !src_class_i.sign && !src_class_i.is_nan;
  assign res_w = src_class_i.is_nan ? nan_value_i :
                 neg_bad ? nan_value_i :
                 is_zero ? inf_neg_i :
                 pos_inf ? inf_pos_i : core_result_i;
  assign exc_w[FLD_EXC_BRANCH_UNORDERED_FLAG] = 1'b0;
  assign exc_w[FLD_EXC_SIGNALLING_NAN_FLAG] = src_class_i.is_signalling_nan_flag;
  assign exc_w[FLD_EXC_OPERAND_ERROR_FLAG] = neg_bad;
  assign exc_w[FLD_EXC_OVERFLOW_FLAG] = 1'b0;
  assign exc_w[FLD_EXC_UNDERFLOW_FLAG] = 1'b0;
  assign exc_w[FLD_EXC_DZ] = is_zero;
  assign exc_w[FLD_EXC_OPERATION_INEXACT_FLAG] = src_class_i.inexact && !src_class_i.is_nan && !neg_bad && !is_zero
                                && !pos_inf;
  assign exc_w[FLD_EXC_DECIMAL_INPUT_INEXACT_FLAG] = (dec_q.rm && (dec_q.fmt == FLD_FMT_PACKED))
                                && src_class_i.decimal_inexact;
  // Accrual: sticky OR of the mapped new exception bits
  assign acc_w[FLD_ACC_IOP] = acc_q[FLD_ACC_IOP] | exc_w[FLD_EXC_BRANCH_UNORDERED_FLAG] | exc_w[FLD_EXC_SIGNALLING_NAN_FLAG]
                              | exc_w[FLD_EXC_OPERAND_ERROR_FLAG];
  assign acc_w[FLD_ACC_OVERFLOW_FLAG] = acc_q[FLD_ACC_OVERFLOW_FLAG] | exc_w[FLD_EXC_OVERFLOW_FLAG];
  assign acc_w[FLD_ACC_UNDERFLOW_FLAG] = acc_q[FLD_ACC_UNDERFLOW_FLAG] | (exc_w[FLD_EXC_UNDERFLOW_FLAG] & exc_w[FLD_EXC_OPERATION_INEXACT_FLAG]);
  assign acc_w[FLD_ACC_DZ] = acc_q[FLD_ACC_DZ] | exc_w[FLD_EXC_DZ];
  assign acc_w[FLD_ACC_INEX] = acc_q[FLD_ACC_INEX] | exc_w[FLD_EXC_DECIMAL_INPUT_INEXACT_FLAG] | exc_w[FLD_EXC_OPERATION_INEXACT_FLAG]
                               | exc_w[FLD_EXC_OVERFLOW_FLAG];
  wire logic finish;
  assign finish = (state_q == FLD_WAIT) && core_done_i;

  // Sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      FLD_IDLE: begin
        if (take) begin
          state_d = FLD_WAIT;
        end
      end
      FLD_WAIT: begin
        if (core_done_i) begin
          state_d = FLD_DONE;
        end
      end
      FLD_DONE: begin
        state_d = FLD_IDLE;
      end
      default: begin
        state_d = FLD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= FLD_IDLE;
      dec_q <= '0;
      accept_q <= 1'b0;
    end else begin
      state_q <= state_d;
      accept_q <= take;
      if (take) begin
        dec_q <= dec_w;
      end else if (finish) begin
        dec_q.valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_en_q <= 1'b0;
      wr_reg_q <= 3'h0;
      wr_data_q <= '0;
      exc_q <= FLD_EXC_RST;
      acc_q <= FLD_ACC_RST;
      irq_q <= 1'b0;
    end else begin
      wr_en_q <= finish;
      if (finish) begin
        wr_reg_q <= dec_q.dst_reg;
        wr_data_q <= res_w;
        exc_q <= exc_w;
        acc_q <= acc_w;
      end
      irq_q <= finish && (exc_w[FLD_EXC_OPERAND_ERROR_FLAG] || exc_w[FLD_EXC_DZ]);
    end
  end

  assign accept_o = accept_q;
  assign decode_o = dec_q;
  assign busy_o = state_q[1];
  assign wr_en_o = wr_en_q;
  assign wr_reg_o = wr_reg_q;
  assign wr_data_o = wr_data_q;
  assign exc_byte_o = exc_q;
  assign acc_byte_o = acc_q;
  assign irq_o = irq_q;
endmodule
`default_nettype wire

/* File: logic/fld_pkg.sv */
// Package for the logarithm instruction decoder: fields, codes, reset values
package fld_pkg;
  localparam int FLD_CP_ID_W = 3;
  localparam logic [3:0] FLD_LINE_F = 4'hf;
  localparam logic [2:0] FLD_TYPE_GENERAL = 3'h0;
  localparam logic [2:0] FLD_CP_ID_RST = 3'h1;
  localparam logic [6:0] FLD_OP_LOG10 = 7'h15;
  localparam logic [6:0] FLD_OP_LOG2 = 7'h16;
  localparam logic [2:0] FLD_FMT_LONG = 3'h0;
  localparam logic [2:0] FLD_FMT_SINGLE = 3'h1;
  localparam logic [2:0] FLD_FMT_EXT = 3'h2;
  localparam logic [2:0] FLD_FMT_PACKED = 3'h3;
  localparam logic [2:0] FLD_FMT_WORD = 3'h4;
  localparam logic [2:0] FLD_FMT_DOUBLE = 3'h5;
  localparam logic [2:0] FLD_FMT_BYTE = 3'h6;
  localparam logic [7:0] FLD_EXC_RST = 8'h00;
  localparam logic [4:0] FLD_ACC_RST = 5'h00;
  // Exception byte bit positions
  localparam int FLD_EXC_BRANCH_UNORDERED_FLAG = 7;
  localparam int FLD_EXC_SIGNALLING_NAN_FLAG = 6;
  localparam int FLD_EXC_OPERAND_ERROR_FLAG = 5;
  localparam int FLD_EXC_OVERFLOW_FLAG = 4;
  localparam int FLD_EXC_UNDERFLOW_FLAG = 3;
  localparam int FLD_EXC_DZ = 2;
  localparam int FLD_EXC_OPERATION_INEXACT_FLAG = 1;
  localparam int FLD_EXC_DECIMAL_INPUT_INEXACT_FLAG = 0;
  // Accrued byte bit positions
  localparam int FLD_ACC_IOP = 4;
  localparam int FLD_ACC_OVERFLOW_FLAG = 3;
  localparam int FLD_ACC_UNDERFLOW_FLAG = 2;
  localparam int FLD_ACC_DZ = 1;
  localparam int FLD_ACC_INEX = 0;

  typedef struct packed {
    logic [3:0] line;
    logic [2:0] cp_id;
    logic [2:0] kind;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
  } fld_word1_t;

  typedef struct packed {
    logic zero15;
    logic rm;
    logic zero13;
    logic [2:0] src_spec;
    logic [2:0] dst_reg;
    logic [6:0] opmode;
  } fld_word2_t;

  // Source operand class as seen after conversion to extended precision
  typedef struct packed {
    logic sign;
    logic is_zero;
    logic is_inf;
    logic is_nan;
    logic is_signalling_nan_flag;
    logic inexact;
    logic decimal_inexact;
  } fld_class_t;

  typedef struct packed {
    logic valid;
    logic log_two;
    logic rm;
    logic [2:0] src_reg;
    logic [2:0] fmt;
    logic [2:0] dst_reg;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic need_convert;
  } fld_decode_t;

  typedef enum logic [2:0] {
    FLD_IDLE = 3'b001,
    FLD_WAIT = 3'b010,
    FLD_DONE = 3'b100
  } fld_state_t;
endpackage

/* File: test/fld_log_decode_chk.sv */
// Port checker for the logarithm decoder
`timescale 1ns/1ps
`default_nettype none
module fld_log_decode_chk #(parameter int RES_W = 80) (
  input wire logic clock_i, rst_n_i, cmd_valid_i, core_done_i, accept_o, busy_o, wr_en_o,
  input wire logic [2:0] cp_id_i, wr_reg_o,
  input wire fld_pkg::fld_word1_t word1_i,
  input wire fld_pkg::fld_word2_t word2_i,
  input wire fld_pkg::fld_class_t src_class_i,
  input wire fld_pkg::fld_decode_t decode_o,
  input wire logic [RES_W-1:0] core_result_i, nan_value_i, inf_pos_i, inf_neg_i, wr_data_o,
  input wire logic [7:0] exc_byte_o,
  input wire logic [4:0] acc_byte_o
);
  import fld_pkg::*;
  logic fin;
  assign fin = core_done_i && busy_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_take_match: assert property (accept_o |-> $past(cmd_valid_i && word1_i.cp_id == cp_id_i))
    else $error("foreign id taken");
  a_src_reg: assert property (accept_o && !decode_o.rm |-> decode_o.src_reg == $past(word2_i.src_spec))
    else $error("bad source reg");
  a_ea_ignore: assert property (accept_o && !decode_o.rm |->
    decode_o.ea_mode == 3'h0 && decode_o.ea_reg == 3'h0 && decode_o.fmt == FLD_FMT_EXT && !decode_o.need_convert)
    else $error("register source decode");
  a_fmt_code: assert property (accept_o && decode_o.rm |->
    decode_o.fmt == $past(word2_i.src_spec) && decode_o.need_convert == (decode_o.fmt != FLD_FMT_EXT))
    else $error("bad format");
  a_dst_clear: assert property (wr_en_o |->
    wr_reg_o == $past(decode_o.dst_reg) && !exc_byte_o[7] && exc_byte_o[4:3] == 2'h0)
    else $error("bad write back");
  a_zero_dz: assert property ($past(fin && src_class_i.is_zero) |->
    wr_en_o && exc_byte_o[FLD_EXC_DZ] && wr_data_o == $past(inf_neg_i))
    else $error("zero source");
  a_neg_err: assert property ($past(fin && src_class_i.sign && !src_class_i.is_zero && !src_class_i.is_nan) |->
    exc_byte_o[FLD_EXC_OPERAND_ERROR_FLAG] && wr_data_o == $past(nan_value_i))
    else $error("negative source");
  a_pos_inf: assert property ($past(fin && src_class_i.is_inf && !src_class_i.sign) |->
    wr_data_o == $past(inf_pos_i) && !exc_byte_o[5] && !exc_byte_o[2])
    else $error("infinite source");
  a_in_range: assert property ($past(fin && src_class_i[6:3] == 4'h0) |->
    wr_data_o == $past(core_result_i) && exc_byte_o[5:2] == 4'h0)
    else $error("in range source");
  a_accrue_iop: assert property (wr_en_o |->
    acc_byte_o[4] == ($past(acc_byte_o[4]) || exc_byte_o[7:5] != 3'h0) && acc_byte_o[1] == ($past(acc_byte_o[1]) || exc_byte_o[2]))
    else $error("accrual");
  c_take_mem: cover property (accept_o && decode_o.rm);
  c_zero: cover property (wr_en_o && exc_byte_o[2]);
  c_neg: cover property (wr_en_o && exc_byte_o[5]);
endmodule
bind fld_log_decode fld_log_decode_chk #(.RES_W(RES_W)) chk_i (.*);
`default_nettype wire

/* File: test/fld_core_model.sv */
// Arithmetic core stand-in: answers each taken operation after a set delay
`timescale 1ns/1ps
`default_nettype none
module fld_core_model (
  input wire logic clock_i, rst_n_i, start_i,
  input wire logic [3:0] lat_i,
  input wire logic [6:0] cls_i,
  output logic done_o,
  output fld_pkg::fld_class_t cls_o
);
  import fld_pkg::*;
  logic run_q;
  logic [3:0] cnt_q;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 1'h0;
      cnt_q <= 4'h0;
      done_o <= 1'h0;
    end else begin
      done_o <= run_q && cnt_q == 4'h0;
      run_q <= start_i || (run_q && cnt_q != 4'h0);
      cnt_q <= start_i ? lat_i : cnt_q - 4'h1;
    end
  end
  // Class of the converted operand, scrambled outside the answer cycle
  assign cls_o = done_o ? cls_i : ~cls_i;
endmodule
`default_nettype wire

/* File: test/fld_log_decode_tb.sv */
// Self-checking bench for the logarithm decoder
`timescale 1ns/1ps
`default_nettype none
module fld_log_decode_tb;
  import fld_pkg::*;
  typedef struct packed {logic two; logic rm; logic [2:0] ss; logic [2:0] dr; logic [6:0] cls; logic [7:0] exc; logic [2:0] d;} fld_row_t;
  logic clock_i = 1'h0, rst_n_i = 1'h0, cmd_valid_i = 1'h0, core_done_i, accept_o, busy_o, wr_en_o, irq_o, got;
  logic [2:0] cp_id_i = 3'h1, wr_reg_o;
  fld_word1_t word1_i = '0;
  fld_word2_t word2_i = '0;
  fld_class_t src_class_i;
  fld_decode_t decode_o;
  logic [79:0] wr_data_o;
  logic [7:0] exc_byte_o, e;
  logic [4:0] acc_byte_o, acc = 5'h0;
  logic [3:0] lat = 4'h0;
  logic [6:0] cls = 7'h0;
  int errors = 0, checks_done = 0;
  fld_row_t rows [11] = '{'{1'h0, 1'h0, 3'h3, 3'h3, 7'h00, 8'h00, 3'h1}, '{1'h1, 1'h0, 3'h1, 3'h5, 7'h40, 8'h20, 3'h2},
    '{1'h0, 1'h1, 3'h1, 3'h5, 7'h02, 8'h02, 3'h1}, '{1'h1, 1'h0, 3'h2, 3'h2, 7'h0c, 8'h40, 3'h2},
    '{1'h0, 1'h1, 3'h6, 3'h2, 7'h20, 8'h04, 3'h4}, '{1'h1, 1'h1, 3'h0, 3'h7, 7'h60, 8'h04, 3'h4},
    '{1'h1, 1'h1, 3'h1, 3'h0, 7'h10, 8'h00, 3'h3}, '{1'h0, 1'h1, 3'h5, 3'h4, 7'h50, 8'h20, 3'h2},
    '{1'h1, 1'h1, 3'h3, 3'h6, 7'h01, 8'h01, 3'h1}, '{1'h0, 1'h1, 3'h4, 3'h1, 7'h01, 8'h00, 3'h1},
    '{1'h1, 1'h1, 3'h2, 3'h2, 7'h00, 8'h00, 3'h1}};
  fld_log_decode #(.RES_W(80)) fld_log_decode_i (.*, .core_result_i(80'h1), .nan_value_i(80'h2),
    .inf_pos_i(80'h3), .inf_neg_i(80'h4));
  fld_core_model fld_core_model_i (.clock_i, .rst_n_i, .start_i(accept_o), .lat_i(lat), .cls_i(cls),
    .done_o(core_done_i), .cls_o(src_class_i));
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic issue(input fld_row_t r, input logic [2:0] id, input logic [6:0] op);
    @(posedge clock_i);
    cmd_valid_i <= 1'h1;
    word1_i <= '{FLD_LINE_F, id, FLD_TYPE_GENERAL, r.rm ? 3'h2 : 3'h0, r.rm ? 3'h1 : 3'h0};
    word2_i <= '{1'h0, r.rm, 1'h0, r.ss, r.dr, op};
    cls <= r.cls;
    @(posedge clock_i);
    cmd_valid_i <= 1'h0;
    got = 1'h0;
    for (int k = 0; k < 40 && !got; k++) begin
      @(posedge clock_i);
      got = wr_en_o === 1'h1;
    end
  endtask
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'h1;
    foreach (rows[i]) begin
      lat <= 4'((i % 4) * 4);
      issue(rows[i], 3'h1, rows[i].two ? FLD_OP_LOG2 : FLD_OP_LOG10);
      chk(got, 1'h1);
      if (!got) wrap_up;
      chk(wr_reg_o, rows[i].dr);
      chk(wr_data_o, 80'(rows[i].d));
      chk(exc_byte_o, rows[i].exc);
      e = rows[i].exc;
      acc = acc | {|e[7:5], e[4], e[3] & e[1], e[2], |{e[4], e[1:0]}};
      chk(acc_byte_o, acc);
      chk(irq_o, e[5] | e[2]);
      $display("row %0d done", i);
    end
    issue(rows[0], 3'h2, FLD_OP_LOG10);
    chk(got, 1'h0);
    issue(rows[0], 3'h1, 7'h14);
    chk(got, 1'h0);
    $display("refusal tests done");
    wrap_up;
  end
endmodule
`default_nettype wire
